// File: rtl/fpo_pkg.sv
// Shared constants, duty table and carrier types for the first fan output block
package fpo_pkg;

	// ==================================================================
	// Register map
	localparam logic [7:0] FPO_ADDR_OVERRIDE = 8'hC9;
	localparam logic [7:0] FPO_ADDR_SPINUP = 8'hCA;
	localparam logic [7:0] FPO_OVERRIDE_RESET = 8'h00;
	localparam logic [7:0] FPO_SPINUP_RESET = 8'h00;

	// Field positions of the override control register
	localparam int FPO_BIT_OVR = 0;
	localparam int FPO_BIT_INV = 1;
	localparam int FPO_BIT_LOCK_EN = 2;
	localparam int FPO_BIT_LOCK_FLAG = 3;
	localparam int FPO_MAN_LSB = 4;
	// Field positions of the spin-up config register
	localparam int FPO_SPINUP_DUTY_CODE_LSB = 0;
	localparam int FPO_SPINUP_DURATION_CODE_LSB = 5;

	// ==================================================================
	// Timing
	localparam int FPO_CLK_PERIOD_NS = 8;
	localparam int FPO_MS_NS = 1000000;
	localparam int FPO_MS_CYCLES = (FPO_MS_NS + FPO_CLK_PERIOD_NS - 1) / FPO_CLK_PERIOD_NS;
	localparam logic [7:0] FPO_RAMP_STEP = 8'h10;
	localparam logic [7:0] FPO_DUTY_FULL = 8'hFF;
	localparam logic [7:0] FPO_DUTY_ZERO = 8'h00;

	// Spin-up durations in milliseconds, indexed by duration code
	localparam logic [7:0][11:0] FPO_SU_MS = {
		12'hFA0, 12'h7D0, 12'h3E8, 12'h2BC, 12'h190, 12'h0FA, 12'h064, 12'h000
	};

	// Duty code to 8-bit duty, one table for every code source
	localparam logic [15:0][7:0] FPO_DUTY_TABLE = {
		8'hFF, 8'hEE, 8'hDD, 8'hCC, 8'hBB, 8'hAA, 8'h99, 8'h88,
		8'h77, 8'h66, 8'h55, 8'h44, 8'h33, 8'h22, 8'h11, 8'h00
	};

	// ==================================================================
	// Carrier types
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fpo_reg_req_s;

	typedef struct packed {
		logic processor_hot_input;
		logic regulator_hot_input;
		logic [7:0] zone_duty;
	} fpo_src_s;

	// ==================================================================
	// Helpers
	function automatic logic [7:0] fpo_code_duty(input logic [3:0] code);
		return FPO_DUTY_TABLE[code];
	endfunction

	// Largest code whose duty does not exceed the given duty
	function automatic logic [3:0] fpo_duty_code(input logic [7:0] duty);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (FPO_DUTY_TABLE[i] <= duty) begin
				c = 4'(i);
			end
		end
		return c;
	endfunction

	function automatic logic [7:0] fpo_max(input logic [7:0] a, input logic [7:0] b);
		return (a > b) ? a : b;
	endfunction

endpackage

// File: rtl/fpo_pwm_core.sv
// Pulse width modulator with output sense selection
`timescale 1ns/1ps
`default_nettype none
module fpo_pwm_core import fpo_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] duty_i,
	input wire logic invert_i,
	output logic pwm_o
);

	typedef struct packed {
		logic [7:0] cnt;
		logic pwm;
	} fpo_pwm_state_s;

	fpo_pwm_state_s s;
	fpo_pwm_state_s next_s;
	logic active;

	// ==================================================================
	// Compare; full duty is held at the active level (low when inverted) with no gap in the period
	always_comb begin
		next_s = s;
		next_s.cnt = s.cnt + 8'h01;
		active = (duty_i == FPO_DUTY_FULL) || (s.cnt < duty_i);
		next_s.pwm = active ^ invert_i;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pwm_o = s.pwm;

	// ==================================================================
	// Checks
	a_full_sense: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(duty_i == FPO_DUTY_FULL) |=> (pwm_o == !$past(invert_i)))
		else $error("full duty output not at steady level");
	a_zero_sense: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(duty_i == FPO_DUTY_ZERO) |=> (pwm_o == $past(invert_i)))
		else $error("zero duty output not at idle level");

endmodule
`default_nettype wire

// File: rtl/fpo_fan_ctrl.sv
// First fan output control: override, hot lock, spin-up and register access
`timescale 1ns/1ps
`default_nettype none
module fpo_fan_ctrl import fpo_pkg::*; #(
	parameter int TICK_CYCLES = FPO_MS_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire fpo_reg_req_s reg_req_i,
	input wire logic cfg_lock_i,
	input wire fpo_src_s src_i,
	input wire logic processor_hot_event_i,
	output logic [7:0] reg_rdata_o,
	output logic hot_lock_flag_o,
	output logic first_fan_output_o
);

	// ==================================================================
	// Elaboration check
	generate
		if (TICK_CYCLES < 2 || TICK_CYCLES > 131071) begin : g_bad_tick
			$error("TICK_CYCLES out of range");
		end
	endgenerate

	typedef struct packed {
		logic manual_override_enable;
		logic output_polarity_invert;
		logic hot_lock_enable;
		logic hot_lock_flag;
		logic [3:0] manual_duty_code;
		logic [3:0] spinup_duty_code;
		logic [2:0] spinup_duration_code;
		logic [7:0] ramp;
		logic [16:0] tick_cnt;
		logic [11:0] ms_left;
		logic spinning;
		logic [7:0] base;
		logic [7:0] applied;
		logic [7:0] rdata;
	} fpo_state_s;

	fpo_state_s s;
	fpo_state_s next_s;
	logic tick;
	logic hot_any;
	logic wr_ovr;
	logic wr_su;
	logic start_spin;
	logic [7:0] base_now;
	logic [7:0] su_duty;

	// ==================================================================
	// Next-state logic
	always_comb begin
		next_s = s;
		// Millisecond tick from the system clock
		tick = (s.tick_cnt == 17'(TICK_CYCLES - 1));
		next_s.tick_cnt = tick ? 17'h00000 : s.tick_cnt + 17'h00001;

		// Hot inputs ramp the duty rather than jumping to it
		hot_any = src_i.processor_hot_input | src_i.regulator_hot_input;
		if (tick && hot_any) begin
			next_s.ramp = (s.ramp > FPO_DUTY_FULL - FPO_RAMP_STEP) ? FPO_DUTY_FULL : s.ramp + FPO_RAMP_STEP;
		end else if (tick) begin
			next_s.ramp = (s.ramp < FPO_RAMP_STEP) ? FPO_DUTY_ZERO : s.ramp - FPO_RAMP_STEP;
		end

		// Every bound source competes for the output; override adds the manual code to the contest
		// rather than silencing the zones, so a hotter zone still shows through the readback
		base_now = fpo_max(src_i.zone_duty, s.ramp);
		if (s.manual_override_enable) begin
			base_now = fpo_max(base_now, fpo_code_duty(s.manual_duty_code));
		end
		next_s.base = base_now;

		// Spin-up on a rise from zero; either code at zero disables it
		su_duty = fpo_code_duty(s.spinup_duty_code);
		start_spin = (s.base == FPO_DUTY_ZERO) && (base_now != FPO_DUTY_ZERO)
			&& (s.spinup_duty_code != 4'h0) && (s.spinup_duration_code != 3'h0);
		if (start_spin) begin
			next_s.spinning = 1'b1;
			next_s.ms_left = FPO_SU_MS[s.spinup_duration_code];
			next_s.tick_cnt = 17'h00000;
		end else if (s.spinning && base_now == FPO_DUTY_ZERO) begin
			next_s.spinning = 1'b0;
		end else if (s.spinning && tick) begin
			next_s.ms_left = s.ms_left - 12'h001;
			next_s.spinning = (s.ms_left != 12'h001);
		end

		// Lock flag: hardware set wins over software clear
		// so an event that meets a clear write in the same cycle is never lost
		wr_ovr = reg_req_i.wr && (reg_req_i.addr == FPO_ADDR_OVERRIDE);
		wr_su = reg_req_i.wr && (reg_req_i.addr == FPO_ADDR_SPINUP);
		if (s.hot_lock_enable && processor_hot_event_i) begin
			next_s.hot_lock_flag = 1'b1;
		end else if (wr_ovr && !reg_req_i.wdata[FPO_BIT_LOCK_FLAG]) begin
			next_s.hot_lock_flag = 1'b0;
		end

		// Other fields are frozen by the configuration lock
		if (wr_ovr && !cfg_lock_i) begin
			next_s.manual_override_enable = reg_req_i.wdata[FPO_BIT_OVR];
			next_s.output_polarity_invert = reg_req_i.wdata[FPO_BIT_INV];
			next_s.hot_lock_enable = reg_req_i.wdata[FPO_BIT_LOCK_EN];
			next_s.manual_duty_code = reg_req_i.wdata[FPO_MAN_LSB +: 4];
		end
		if (wr_su && !cfg_lock_i) begin
			next_s.spinup_duty_code = reg_req_i.wdata[FPO_SPINUP_DUTY_CODE_LSB +: 4];
			next_s.spinup_duration_code = reg_req_i.wdata[FPO_SPINUP_DURATION_CODE_LSB +: 3];
		end

		// Applied duty: lock over spin-up over the plain request
		if (s.hot_lock_flag) begin
			next_s.applied = FPO_DUTY_FULL;
		end else if (s.spinning) begin
			next_s.applied = fpo_max(s.base, su_duty);
		end else begin
			next_s.applied = s.base;
		end

		// Read data; the duty field reports what is applied, not what was written
		if (reg_req_i.rd && reg_req_i.addr == FPO_ADDR_OVERRIDE) begin
			next_s.rdata = {fpo_duty_code(s.applied), s.hot_lock_flag, s.hot_lock_enable,
				s.output_polarity_invert, s.manual_override_enable};
		end else if (reg_req_i.rd && reg_req_i.addr == FPO_ADDR_SPINUP) begin
			next_s.rdata = {s.spinup_duration_code, 1'b0, s.spinup_duty_code};
		end else if (reg_req_i.rd) begin
			next_s.rdata = 8'h00;
		end
	end

	// ==================================================================
	// State register
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
			s.manual_override_enable <= FPO_OVERRIDE_RESET[FPO_BIT_OVR];
			s.output_polarity_invert <= FPO_OVERRIDE_RESET[FPO_BIT_INV];
			s.hot_lock_enable <= FPO_OVERRIDE_RESET[FPO_BIT_LOCK_EN];
			s.hot_lock_flag <= FPO_OVERRIDE_RESET[FPO_BIT_LOCK_FLAG];
			s.manual_duty_code <= FPO_OVERRIDE_RESET[FPO_MAN_LSB +: 4];
			s.spinup_duty_code <= FPO_SPINUP_RESET[FPO_SPINUP_DUTY_CODE_LSB +: 4];
			s.spinup_duration_code <= FPO_SPINUP_RESET[FPO_SPINUP_DURATION_CODE_LSB +: 3];
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata_o = s.rdata;
	assign hot_lock_flag_o = s.hot_lock_flag;

	// ==================================================================
	// Output stage; duty reaches the pin one cycle after it is applied
	fpo_pwm_core u_pwm (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.duty_i(s.applied),
		.invert_i(s.output_polarity_invert),
		.pwm_o(first_fan_output_o)
	);

	// ==================================================================
	// Checks
	a_lock_full_duty: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		s.hot_lock_flag |=> (s.applied == FPO_DUTY_FULL))
		else $error("locked output not at full duty");
	a_flag_set_cause: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(s.hot_lock_flag) |-> ($past(s.hot_lock_enable) && $past(processor_hot_event_i)))
		else $error("lock flag set without enabled event");
	a_flag_clear_cause: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$fell(s.hot_lock_flag) |-> ($past(wr_ovr) && !$past(reg_req_i.wdata[FPO_BIT_LOCK_FLAG])))
		else $error("lock flag cleared without zero write");
	a_flag_under_lock: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(cfg_lock_i && wr_ovr && !reg_req_i.wdata[FPO_BIT_LOCK_FLAG] && !processor_hot_event_i)
		|=> !s.hot_lock_flag)
		else $error("lock flag not cleared under config lock");
	a_manual_floor: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		s.manual_override_enable |=> (s.base >= fpo_code_duty($past(s.manual_duty_code))))
		else $error("manual duty not applied");
	a_source_max: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		!s.manual_override_enable |=> (s.base >= $past(src_i.zone_duty)) ##1 (s.applied >= $past(s.base)))
		else $error("largest source not applied");
	a_spin_start: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		start_spin |=> s.spinning ##1 ((s.applied >= fpo_code_duty($past(s.spinup_duty_code))) || s.hot_lock_flag
		|| !s.spinning))
		else $error("spin-up did not start");
	a_spin_disabled: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(s.spinning) |-> ($past(s.spinup_duty_code) != 4'h0 && $past(s.spinup_duration_code) != 3'h0))
		else $error("spin-up started while disabled");
	a_readback_code: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(reg_req_i.rd && reg_req_i.addr == FPO_ADDR_OVERRIDE)
		|=> (reg_rdata_o[7:4] == fpo_duty_code($past(s.applied))))
		else $error("readback code not applied duty");
	a_zone_with_ovr: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		s.manual_override_enable |=> (s.base >= $past(src_i.zone_duty)))
		else $error("zone request lost under override");
	a_ramp_rises: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(tick && hot_any) |=> (s.ramp >= $past(s.ramp)))
		else $error("hot input did not ramp up");
	a_tick_restart: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		start_spin |=> (s.tick_cnt == 17'h00000))
		else $error("tick count not restarted at spin-up");
	a_spin_expiry: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(s.spinning && tick && s.ms_left == 12'h001 && base_now != FPO_DUTY_ZERO)
		|=> !s.spinning)
		else $error("spin-up outlived its duration");

endmodule
`default_nettype wire

// File: dv/fpo_fan_drive.sv
// Fan driver stage model that integrates the drive level of the first fan output
`timescale 1ns/1ps
`default_nettype none
module fpo_fan_drive (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic drive_i,
	output logic [8:0] high_count_o
);
	logic [7:0] phase;
	logic [8:0] acc;
	// Frame equals the modulator period, so a steady duty gives an exact count
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase <= 8'h00;
			acc <= 9'h000;
			high_count_o <= 9'h000;
		end else begin
			phase <= phase + 8'h01;
			if (phase == 8'hFF) begin
				high_count_o <= acc + {8'h00, drive_i};
				acc <= 9'h000;
			end else begin
				acc <= acc + {8'h00, drive_i};
			end
		end
	end
endmodule
`default_nettype wire

// File: dv/fpo_fan_ctrl_test.sv
// Self-checking testbench for the first fan output control block
`timescale 1ns/1ps
`default_nettype none
module fpo_fan_ctrl_test;
	import fpo_pkg::*;
	// Short tick keeps the longest spin-up within a short run
	localparam int TICK = 4;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	fpo_reg_req_s req = '0;
	logic cfg_lock = 1'b0;
	fpo_src_s src = '0;
	logic hot_evt = 1'b0;
	logic [7:0] rdata;
	logic flag;
	logic pwm;
	logic [8:0] highs;
	int failures = 0;
	int check_count = 0;
	int su_ms [8] = '{0, 100, 250, 400, 700, 1000, 2000, 4000};
	int duty;

	fpo_fan_ctrl #(.TICK_CYCLES(TICK)) u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.reg_req_i(req), .cfg_lock_i(cfg_lock), .src_i(src), .processor_hot_event_i(hot_evt),
		.reg_rdata_o(rdata), .hot_lock_flag_o(flag), .first_fan_output_o(pwm));
	fpo_fan_drive u_fan (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .drive_i(pwm), .high_count_o(highs));

	initial begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	// ==================================================================
	// Access tasks
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		step(1);
		req.wr = 1'b0;
		// An idle edge between writes keeps the strobe from changing twice in one time step
		step(1);
	endtask
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask
	// Read data is registered at the strobe edge, so it is sampled one edge later
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		req.rd = 1'b1;
		req.addr = a;
		step(1);
		req.rd = 1'b0;
		step(1);
		chk($sformatf("register %0h", a), {1'b0, exp}, {1'b0, rdata});
	endtask
	task automatic end_sim;
		if (failures == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==================================================================
	// Scenarios
	initial begin
		step(5);
		resetn_i = 1'b1;
		step(1);
		chk_reg(FPO_ADDR_OVERRIDE, 8'h00);
		chk_reg(FPO_ADDR_SPINUP, 8'h00);
		chk_reg(8'h55, 8'h00);
		wr(FPO_ADDR_SPINUP, 8'hFF);
		chk_reg(FPO_ADDR_SPINUP, 8'hEF);
		wr(FPO_ADDR_SPINUP, 8'h00);
		// Manual codes in both senses, measured at the fan
		for (int c = 0; c < 16; c += 5) begin
			for (int v = 0; v < 2; v++) begin
				wr(FPO_ADDR_OVERRIDE, {4'(c), 2'b00, 1'(v), 1'b1});
				step(600);
				duty = (c == 15) ? 256 : c * 17;
				chk("fan high cycles", 9'((v == 1) ? 256 - duty : duty), highs);
				chk_reg(FPO_ADDR_OVERRIDE, {4'(c), 2'b00, 1'(v), 1'b1});
			end
		end
		// A zone asking for more wins over the manual code
		src.zone_duty = 8'h99;
		wr(FPO_ADDR_OVERRIDE, 8'h21);
		step(8);
		chk_reg(FPO_ADDR_OVERRIDE, 8'h91);
		src = '0;
		wr(FPO_ADDR_OVERRIDE, 8'h00);
		// Each hot input ramps to full and back to zero
		for (int h = 0; h < 2; h++) begin
			src.processor_hot_input = (h == 0);
			src.regulator_hot_input = (h == 1);
			step(24 * TICK);
			chk_reg(FPO_ADDR_OVERRIDE, 8'hF0);
			src = '0;
			step(24 * TICK);
			chk_reg(FPO_ADDR_OVERRIDE, 8'h00);
		end
		// Hot lock: ignored while disabled, then set, held and released
		wr(FPO_ADDR_OVERRIDE, 8'h01);
		hot_evt = 1'b1;
		step(1);
		hot_evt = 1'b0;
		step(2);
		chk("lock flag", 9'h000, {8'h00, flag});
		wr(FPO_ADDR_OVERRIDE, 8'h05);
		hot_evt = 1'b1;
		step(1);
		hot_evt = 1'b0;
		step(2);
		chk("lock flag", 9'h001, {8'h00, flag});
		step(600);
		chk("fan high cycles", 9'h100, highs);
		chk_reg(FPO_ADDR_OVERRIDE, 8'hFD);
		wr(FPO_ADDR_OVERRIDE, 8'h0D);
		step(2);
		chk("lock flag", 9'h001, {8'h00, flag});
		cfg_lock = 1'b1;
		wr(FPO_ADDR_OVERRIDE, 8'h00);
		step(2);
		chk("lock flag", 9'h000, {8'h00, flag});
		chk_reg(FPO_ADDR_OVERRIDE, 8'h05);
		step(600);
		chk("fan high cycles", 9'h000, highs);
		cfg_lock = 1'b0;
		// Spin-up off by duration code 0, then by duty code 0
		for (int k = 0; k < 2; k++) begin
			wr(FPO_ADDR_OVERRIDE, 8'h01);
			wr(FPO_ADDR_SPINUP, (k == 0) ? 8'h08 : 8'h20);
			wr(FPO_ADDR_OVERRIDE, 8'h21);
			step(8);
			chk_reg(FPO_ADDR_OVERRIDE, 8'h21);
		end
		// Every duration, each rise from zero restarting the count
		for (int d = 1; d < 8; d++) begin
			wr(FPO_ADDR_OVERRIDE, 8'h01);
			wr(FPO_ADDR_SPINUP, {3'(d), 5'h08});
			step(4);
			wr(FPO_ADDR_OVERRIDE, 8'h21);
			step(su_ms[d] * TICK - 3 * TICK);
			chk_reg(FPO_ADDR_OVERRIDE, 8'h81);
			step(5 * TICK);
			chk_reg(FPO_ADDR_OVERRIDE, 8'h21);
		end
		end_sim();
	end

	// A run far past the longest sequence counts as a failure
	initial begin
		#600000;
		failures++;
		end_sim();
	end
endmodule
`default_nettype wire
